// ### core/rtcal_pkg.sv
// Shared constants for the alarm and time-stamp block: register map, field layout,
// reset values and the interrupt pulse timing.
// Assumes a byte-wide register port driven by the serial slave outside this block.
package rtcal_pkg;

  // Register byte addresses
  localparam logic [7:0] ADDR_STATUS = 8'h0a;
  localparam logic [7:0] ADDR_EVT_COUNT = 8'h0b;
  localparam logic [7:0] ADDR_CTRL = 8'h0c;
  localparam logic [7:0] ADDR_POWER = 8'h11;
  localparam logic [7:0] ADDR_ALARM0 = 8'h1d;
  localparam logic [7:0] ADDR_ALARM1 = 8'h23;
  localparam logic [7:0] ADDR_STAMP_BASE = 8'h40;

  // Time and alarm field order, matching the register order
  localparam int NUM_FIELDS = 6;
  localparam int FLD_SEC = 0;
  localparam int FLD_MIN = 1;
  localparam int FLD_HOUR = 2;
  localparam int FLD_DATE = 3;
  localparam int FLD_MONTH = 4;
  localparam int FLD_WDAY = 5;
  localparam int NUM_ALARMS = 2;

  // Alarm byte: top bit is the compare enable, the rest mirrors the time byte
  localparam int ALARM_EN_BIT = 7;
  localparam logic [NUM_FIELDS-1:0][7:0] ALARM_RESET =
    {8'h00, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00};

  // Control register fields
  localparam int CTRL_AUTOCLR_BIT = 7;
  localparam int CTRL_PERIODIC_BIT = 6;
  localparam int CTRL_EN1_BIT = 5;
  localparam int CTRL_EN0_BIT = 4;
  localparam logic [7:0] CTRL_MASK = 8'hf0;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // Status register fields
  localparam int STAT_FLAG0_BIT = 0;
  localparam int STAT_FLAG1_BIT = 1;

  // Power control register: stamp clear, self-clearing
  localparam int POWER_STAMP_CLEAR_BIT = 7;

  // Stamps: seconds through month, five bytes per entry, eight-byte address stride
  localparam int STAMP_BYTES = 5;
  localparam int STAMP_W = STAMP_BYTES * 8;
  localparam int NUM_STAMPS = 6;
  localparam int STAMP_STRIDE_LOG2 = 3;
  localparam int STAMP_LOSS = 0;
  localparam int STAMP_RETURN = 1;
  localparam int STAMP_FIRST = 2;
  localparam int STAMP_RECENT = 3;
  localparam logic [7:0] EVT_COUNT_MAX = 8'hff;

  // Pulse-mode interrupt width, rounded up to whole clocks
  localparam int CLK_PERIOD_NS = 25;
  localparam int IRQ_PULSE_NS = 1000;
  localparam int IRQ_PULSE_CYCLES = (IRQ_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [0:0] {
    RTCAL_IRQ_IDLE = 1'b0,
    RTCAL_IRQ_PULSE = 1'b1
  } rtcal_irq_st_t;

endpackage : rtcal_pkg

// ### core/rtcal_stamp_if.sv
// Carrier between the main block and the stamp store: capture and clear
// strobes, the time snapshot and the read port of the stamp array.
// Assumes both ends run on the same clock.
`timescale 1ns/10ps
interface rtcal_stamp_if;
  logic cap_loss;
  logic cap_return;
  logic cap_event;
  logic clr_power;
  logic clr_event;
  logic [rtcal_pkg::STAMP_W-1:0] snap;
  logic [2:0] rd_entry;
  logic [rtcal_pkg::STAMP_W-1:0] rd_word;

  modport ctrl (
    output cap_loss, cap_return, cap_event, clr_power, clr_event, snap, rd_entry,
    input rd_word
  );
  modport store (
    input cap_loss, cap_return, cap_event, clr_power, clr_event, snap, rd_entry,
    output rd_word
  );
endinterface : rtcal_stamp_if

// ### core/rtcal_alarm_match.sv
// Combinational compare of one alarm's six bytes with the running time.
// Assumes time bytes are stable while compared; the caller times the compare.
`timescale 1ns/10ps
module rtcal_alarm_match (
  input wire logic [rtcal_pkg::NUM_FIELDS-1:0][7:0] alarm_i,
  input wire logic [rtcal_pkg::NUM_FIELDS-1:0][7:0] time_i,
  output logic any_en_o,
  output logic match_o
);
  logic [rtcal_pkg::NUM_FIELDS-1:0] en;
  logic [rtcal_pkg::NUM_FIELDS-1:0] hit;

  // [RULE1] enable bit, field compare
  // [RULE2] six fields only
  for (genvar f = 0; f < rtcal_pkg::NUM_FIELDS; f++) begin : g_fld
    assign en[f] = alarm_i[f][rtcal_pkg::ALARM_EN_BIT];
    assign hit[f] = ~en[f] |
      (alarm_i[f][rtcal_pkg::ALARM_EN_BIT-1:0] == time_i[f][rtcal_pkg::ALARM_EN_BIT-1:0]);
  end

  assign any_en_o = |en;
  // [RULE3] all enabled fields equal
  assign match_o = (&hit) & (|en);
endmodule : rtcal_alarm_match

// ### core/rtcal_stamp_store.sv
// Stamp array: supply loss, supply return, first event and three recent events.
// Assumes capture strobes are one-cycle pulses; clears act before captures.
`timescale 1ns/10ps
module rtcal_stamp_store #(
  parameter int NUM_STAMPS = rtcal_pkg::NUM_STAMPS
) (
  input wire logic core_clk_i,
  input wire logic reset_i,
  rtcal_stamp_if.store sif
);
  if (NUM_STAMPS <= rtcal_pkg::STAMP_RECENT || NUM_STAMPS > 8) begin : g_chk
    $error("rtcal_stamp_store: NUM_STAMPS out of range");
  end

  logic [rtcal_pkg::STAMP_W-1:0] mem_q [NUM_STAMPS];
  logic [rtcal_pkg::STAMP_W-1:0] mem_d [NUM_STAMPS];
  logic loss_held_q, loss_held_d;
  logic first_held_q, first_held_d;

  always_comb begin
    mem_d = mem_q;
    loss_held_d = loss_held_q;
    first_held_d = first_held_q;
    // [RULE13] clear both supply stamps
    if (sif.clr_power) begin
      mem_d[rtcal_pkg::STAMP_LOSS] = '0;
      mem_d[rtcal_pkg::STAMP_RETURN] = '0;
      loss_held_d = 1'b0;
    end
    // [RULE12] first loss only
    if (sif.cap_loss && !loss_held_d) begin
      mem_d[rtcal_pkg::STAMP_LOSS] = sif.snap;
      loss_held_d = 1'b1;
    end
    // [RULE14] latest return overwrites
    if (sif.cap_return) begin
      mem_d[rtcal_pkg::STAMP_RETURN] = sif.snap;
    end
    // [RULE16] clear all event stamps
    if (sif.clr_event) begin
      for (int i = rtcal_pkg::STAMP_FIRST; i < NUM_STAMPS; i++) begin
        mem_d[i] = '0;
      end
      first_held_d = 1'b0;
    end
    // [RULE15] frozen first, shifting recent
    if (sif.cap_event) begin
      if (!first_held_d) begin
        mem_d[rtcal_pkg::STAMP_FIRST] = sif.snap;
        first_held_d = 1'b1;
      end
      for (int i = NUM_STAMPS - 1; i > rtcal_pkg::STAMP_RECENT; i--) begin
        mem_d[i] = mem_d[i-1];
      end
      mem_d[rtcal_pkg::STAMP_RECENT] = sif.snap;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      // [RULE17] stamps reset to zero
      for (int i = 0; i < NUM_STAMPS; i++) begin
        mem_q[i] <= '0;
      end
      loss_held_q <= 1'b0;
      first_held_q <= 1'b0;
    end else begin
      mem_q <= mem_d;
      loss_held_q <= loss_held_d;
      first_held_q <= first_held_d;
    end
  end

  // Out-of-range entries are filtered by the caller's address decode
  assign sif.rd_word = mem_q[sif.rd_entry];
endmodule : rtcal_stamp_store

// ### core/rtcal_top.sv
// Dual alarm compare, shared interrupt line and event time-stamp capture.
// Assumes time_i holds the new time in the cycle tick_i pulses, and a byte-wide
// register port from the serial slave with one-cycle write and read strobes.
//
// Contract
// [RULE1] Alarm byte mirrors time byte; top bit enables its compare.
// [RULE2] No year alarm; six fields seconds through weekday.
// [RULE3] Alarm triggers when all enabled fields equal the running time.
// [RULE4] Enabled alarm with periodic select 0 runs single-event mode.
// [RULE5] Single-event match sets flag and holds interrupt low until cleared.
// [RULE6] One shared interrupt; high again only when both flags cleared.
// [RULE7] Periodic select 1: interrupt pulses on every match of either alarm.
// [RULE8] Host clears a flag by writing 0 to it in status.
// [RULE9] Auto-clear bit set: status read clears both alarm flags.
// [RULE10] Pulse mode sets flag each trigger; pulsing ignores flag handling.
// [RULE11] Seconds disabled: fire on entering the matching minute only.
// [RULE12] Supply-loss stamp takes first switch to battery only.
// [RULE13] Writing 1 to stamp clear wipes both supply stamps.
// [RULE14] Supply-return stamp keeps the latest return to main supply.
// [RULE15] Event stamps: frozen first event plus three most recent.
// [RULE16] Writing zero to event counter clears all four event stamps.
// [RULE17] Cleared stamps read all zero, meaning no capture yet.
// [RULE18] Pulse-mode interrupt is one fixed-width low pulse per match.
`timescale 1ns/10ps
module rtcal_top #(
  parameter int IRQ_PULSE_CYCLES = rtcal_pkg::IRQ_PULSE_CYCLES
) (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  input wire logic [rtcal_pkg::NUM_FIELDS-1:0][7:0] time_i,
  input wire logic tick_i,
  input wire logic on_battery_i,
  input wire logic event_i,
  output logic irq_n_o
);
  localparam int PCW = $clog2(IRQ_PULSE_CYCLES + 1);

  // Width must end well before the next one-second match
  if (IRQ_PULSE_CYCLES < 1 || IRQ_PULSE_CYCLES > 4096) begin : g_chk
    $error("rtcal_top: IRQ_PULSE_CYCLES out of range");
  end

  localparam int NA = rtcal_pkg::NUM_ALARMS;
  localparam int NF = rtcal_pkg::NUM_FIELDS;
  localparam int STAMP_END = int'(rtcal_pkg::ADDR_STAMP_BASE) +
    (rtcal_pkg::NUM_STAMPS << rtcal_pkg::STAMP_STRIDE_LOG2);

  // The alarm bytes must end below the stamp window, which must fit the byte address space
  if (int'(rtcal_pkg::ADDR_ALARM0) + NA * NF > int'(rtcal_pkg::ADDR_STAMP_BASE) ||
      STAMP_END > 256) begin : g_map_chk
    $error("rtcal_top: register map overlaps or overflows");
  end

  // A stamp must fit its address stride, and the entry index is three bits wide
  if (rtcal_pkg::STAMP_BYTES > (1 << rtcal_pkg::STAMP_STRIDE_LOG2) ||
      rtcal_pkg::NUM_STAMPS > 8) begin : g_stamp_chk
    $error("rtcal_top: stamp layout does not fit its address window");
  end

  // One enable bit per alarm, all of them below the periodic select
  if (rtcal_pkg::CTRL_EN0_BIT + NA > rtcal_pkg::CTRL_PERIODIC_BIT) begin : g_ctrl_chk
    $error("rtcal_top: alarm enable bits collide with the mode bits");
  end

  // Register state
  logic [NA-1:0][NF-1:0][7:0] alarm_q, alarm_d;
  logic [7:0] ctrl_q, ctrl_d;
  logic [NA-1:0] flag_q, flag_d;
  logic [7:0] evt_cnt_q, evt_cnt_d;
  logic [7:0] rdata_q, rdata_d;

  // Alarm match history and battery edge state
  logic [NA-1:0] match_prev_q, match_prev_d;
  logic batt_q, batt_d;

  // Interrupt state
  rtcal_pkg::rtcal_irq_st_t irq_st_q, irq_st_d;
  logic [PCW-1:0] pulse_cnt_q, pulse_cnt_d;
  logic irq_n_q, irq_n_d;

  // Decode
  logic wr_status, rd_status, wr_ctrl, wr_power, wr_evt_cnt;
  logic in_stamp, stamp_rd;
  // One select per alarm byte, shared by the write and the read side
  logic [NA*NF-1:0] alarm_sel;
  logic [2:0] stamp_byte;
  logic [NA-1:0] any_en, match, active, trig;
  logic periodic, auto_clr;

  rtcal_stamp_if sif ();

  assign wr_status = reg_wr_i && (reg_addr_i == rtcal_pkg::ADDR_STATUS);
  assign rd_status = reg_rd_i && (reg_addr_i == rtcal_pkg::ADDR_STATUS);
  assign wr_ctrl = reg_wr_i && (reg_addr_i == rtcal_pkg::ADDR_CTRL);
  assign wr_power = reg_wr_i && (reg_addr_i == rtcal_pkg::ADDR_POWER);
  assign wr_evt_cnt = reg_wr_i && (reg_addr_i == rtcal_pkg::ADDR_EVT_COUNT);

  // Compared at nine bits so a window that ends at the top of the map still decodes
  assign in_stamp = (reg_addr_i >= rtcal_pkg::ADDR_STAMP_BASE) &&
    ({1'b0, reg_addr_i} < 9'(STAMP_END));
  assign stamp_rd = in_stamp && (stamp_byte < 3'(rtcal_pkg::STAMP_BYTES));
  assign stamp_byte = reg_addr_i[rtcal_pkg::STAMP_STRIDE_LOG2-1:0];

  assign periodic = ctrl_q[rtcal_pkg::CTRL_PERIODIC_BIT];
  assign auto_clr = ctrl_q[rtcal_pkg::CTRL_AUTOCLR_BIT];

  for (genvar e = 0; e < NA * NF; e++) begin : g_asel
    localparam logic [7:0] BYTE_ADDR = 8'(int'(rtcal_pkg::ADDR_ALARM0) + e);
    assign alarm_sel[e] = (reg_addr_i == BYTE_ADDR);
  end

  for (genvar a = 0; a < NA; a++) begin : g_alarm
    rtcal_alarm_match u_match (
      .alarm_i (alarm_q[a]),
      .time_i (time_i),
      .any_en_o (any_en[a]),
      .match_o (match[a])
    );
    // [RULE4] alarm enable plus any field
    assign active[a] = ctrl_q[rtcal_pkg::CTRL_EN0_BIT + a] & any_en[a];
    // [RULE11] fire only on entering the match
    assign trig[a] = tick_i & active[a] & match[a] & ~match_prev_q[a];
  end

  // Stamp control: the stamp store sees the whole seconds-through-month snapshot
  assign sif.snap = time_i[rtcal_pkg::FLD_MONTH:rtcal_pkg::FLD_SEC];
  assign sif.cap_loss = on_battery_i & ~batt_q;
  assign sif.cap_return = ~on_battery_i & batt_q;
  assign sif.cap_event = event_i;
  // [RULE13] stamp clear strobe
  assign sif.clr_power = wr_power & reg_wdata_i[rtcal_pkg::POWER_STAMP_CLEAR_BIT];
  // [RULE16] zero write clears events
  assign sif.clr_event = wr_evt_cnt & (reg_wdata_i == 8'h00);
  // Index held at zero outside the window so the array is never read past its end
  assign sif.rd_entry = stamp_rd ? reg_addr_i[rtcal_pkg::STAMP_STRIDE_LOG2 +: 3] : 3'h0;

  rtcal_stamp_store #(
    .NUM_STAMPS (rtcal_pkg::NUM_STAMPS)
  ) u_stamp (
    .core_clk_i (core_clk_i),
    .reset_i (reset_i),
    .sif (sif)
  );

  // Register file: writes, flags and read data
  always_comb begin
    alarm_d = alarm_q;
    ctrl_d = ctrl_q;
    flag_d = flag_q;
    evt_cnt_d = evt_cnt_q;
    rdata_d = rdata_q;
    for (int a = 0; a < NA; a++) begin
      for (int f = 0; f < NF; f++) begin
        if (reg_wr_i && alarm_sel[a * NF + f]) begin
          alarm_d[a][f] = reg_wdata_i;
        end
      end
    end
    // Reserved low control bits are dropped on write and read back zero
    if (wr_ctrl) begin
      ctrl_d = reg_wdata_i & rtcal_pkg::CTRL_MASK;
    end
    // [RULE8] write 0 clears, write 1 keeps
    if (wr_status) begin
      flag_d[0] = flag_q[0] & reg_wdata_i[rtcal_pkg::STAT_FLAG0_BIT];
      flag_d[1] = flag_q[1] & reg_wdata_i[rtcal_pkg::STAT_FLAG1_BIT];
    end
    // [RULE9] auto-clear on status read
    if (rd_status && auto_clr) begin
      flag_d = '0;
    end
    // [RULE5] set on match, beats a clear
    // [RULE10] pulse mode also sets the flag
    flag_d = flag_d | trig;
    // Counter saturates so a long burst cannot wrap back to zero
    if (wr_evt_cnt) begin
      evt_cnt_d = reg_wdata_i;
    end else if (event_i && evt_cnt_q != rtcal_pkg::EVT_COUNT_MAX) begin
      evt_cnt_d = evt_cnt_q + 8'h01;
    end
    if (reg_rd_i) begin
      rdata_d = 8'h00;
      if (reg_addr_i == rtcal_pkg::ADDR_STATUS) begin
        rdata_d[rtcal_pkg::STAT_FLAG0_BIT] = flag_q[0];
        rdata_d[rtcal_pkg::STAT_FLAG1_BIT] = flag_q[1];
      end else if (reg_addr_i == rtcal_pkg::ADDR_EVT_COUNT) begin
        rdata_d = evt_cnt_q;
      end else if (reg_addr_i == rtcal_pkg::ADDR_CTRL) begin
        rdata_d = ctrl_q;
      end else if (reg_addr_i == rtcal_pkg::ADDR_POWER) begin
        // Stamp clear acts once and is not stored, so this byte reads back zero
        rdata_d = 8'h00;
      end else if (stamp_rd) begin
        // [RULE17] cleared stamp reads zero
        rdata_d = sif.rd_word[stamp_byte*8 +: 8];
      end
      for (int a = 0; a < NA; a++) begin
        for (int f = 0; f < NF; f++) begin
          if (alarm_sel[a * NF + f]) begin
            rdata_d = alarm_q[a][f];
          end
        end
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      alarm_q <= {NA{rtcal_pkg::ALARM_RESET}};
      ctrl_q <= rtcal_pkg::CTRL_RESET;
      flag_q <= '0;
      evt_cnt_q <= 8'h00;
      rdata_q <= 8'h00;
    end else begin
      alarm_q <= alarm_d;
      ctrl_q <= ctrl_d;
      flag_q <= flag_d;
      evt_cnt_q <= evt_cnt_d;
      rdata_q <= rdata_d;
    end
  end

  // Match history only moves on a time step, so a long match fires once
  always_comb begin
    match_prev_d = match_prev_q;
    if (tick_i) begin
      match_prev_d = match & active;
    end
    batt_d = on_battery_i;
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      match_prev_q <= '0;
      batt_q <= 1'b0;
    end else begin
      match_prev_q <= match_prev_d;
      batt_q <= batt_d;
    end
  end

  // Shared interrupt line
  always_comb begin
    irq_st_d = irq_st_q;
    pulse_cnt_d = pulse_cnt_q;
    irq_n_d = 1'b1;
    if (!periodic) begin
      irq_st_d = rtcal_pkg::RTCAL_IRQ_IDLE;
      pulse_cnt_d = '0;
      // [RULE5] low while a flag stands
      // [RULE6] high only when both clear
      irq_n_d = ~(|flag_d);
    end else begin
      // [RULE7] pulse on each match
      // [RULE18] fixed pulse width
      case (irq_st_q)
        rtcal_pkg::RTCAL_IRQ_IDLE: begin
          if (|trig) begin
            irq_st_d = rtcal_pkg::RTCAL_IRQ_PULSE;
            pulse_cnt_d = PCW'(IRQ_PULSE_CYCLES - 1);
            irq_n_d = 1'b0;
          end
        end
        rtcal_pkg::RTCAL_IRQ_PULSE: begin
          // A match inside a pulse restarts it rather than stacking a second one
          if (|trig) begin
            pulse_cnt_d = PCW'(IRQ_PULSE_CYCLES - 1);
            irq_n_d = 1'b0;
          end else if (pulse_cnt_q == '0) begin
            irq_st_d = rtcal_pkg::RTCAL_IRQ_IDLE;
          end else begin
            pulse_cnt_d = pulse_cnt_q - PCW'(1);
            irq_n_d = 1'b0;
          end
        end
        default: begin
          irq_st_d = rtcal_pkg::RTCAL_IRQ_IDLE;
          pulse_cnt_d = '0;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      irq_st_q <= rtcal_pkg::RTCAL_IRQ_IDLE;
      pulse_cnt_q <= '0;
      irq_n_q <= 1'b1;
    end else begin
      irq_st_q <= irq_st_d;
      pulse_cnt_q <= pulse_cnt_d;
      irq_n_q <= irq_n_d;
    end
  end

  assign irq_n_o = irq_n_q;
  assign reg_rdata_o = rdata_q;
endmodule : rtcal_top

// ### test/rtcal_host.sv
// Host-side register master for the alarm and stamp block.
// Assumes strobes are taken on the rising edge and read data lands one edge later.
`timescale 1ns/10ps
module rtcal_host (
  input wire logic core_clk_i,
  input wire logic [7:0] reg_rdata_i,
  output logic [7:0] reg_addr_o,
  output logic [7:0] reg_wdata_o,
  output logic reg_wr_o,
  output logic reg_rd_o
);
  initial begin
    reg_addr_o = 8'h00;
    reg_wdata_o = 8'h00;
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
  end

  // flag and stamp clears are plain writes
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk_i);
    reg_addr_o = a;
    reg_wdata_o = d;
    reg_wr_o = 1'b1;
    @(negedge core_clk_i);
    reg_wr_o = 1'b0;
    // Stale data is scrambled so nothing can lean on it
    reg_wdata_o = ~d;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge core_clk_i);
    reg_addr_o = a;
    reg_rd_o = 1'b1;
    @(negedge core_clk_i);
    reg_rd_o = 1'b0;
    d = reg_rdata_i;
  endtask : rd
endmodule : rtcal_host

// ### test/rtcal_sva.sv
// Port-level checker for the alarm and stamp block, bound to its top module.
// Assumes control bits are only changed through the register port.
`timescale 1ns/10ps
module rtcal_sva #(
  parameter int IRQ_PULSE_CYCLES = rtcal_pkg::IRQ_PULSE_CYCLES
) (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic [rtcal_pkg::NUM_FIELDS-1:0][7:0] time_i,
  input wire logic tick_i,
  input wire logic on_battery_i,
  input wire logic event_i,
  input wire logic irq_n_o
);
  logic per_q, per_d;
  logic [15:0] low_q, low_d;

  // Shadow of the periodic select bit, needed to tell pulse from level
  always_comb begin
    per_d = per_q;
    if (reg_wr_i && reg_addr_i == rtcal_pkg::ADDR_CTRL) begin
      per_d = reg_wdata_i[rtcal_pkg::CTRL_PERIODIC_BIT];
    end
    low_d = irq_n_o ? 16'h0000 : low_q + 16'h0001;
    if (reset_i) begin
      per_d = 1'b0;
      low_d = 16'h0000;
    end
  end

  always_ff @(posedge core_clk_i) begin
    per_q <= per_d;
    low_q <= low_d;
  end

  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (reset_i);

  a_reset_idle: assert property ($fell(reset_i) |-> irq_n_o && reg_rdata_o == 8'h00)
    else $error("outputs not idle after reset");
  a_rdata_hold: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
    else $error("read data moved without a read");
  a_year_slot: assert property (reg_rd_i && reg_addr_i == 8'h29 |=> reg_rdata_o == 8'h00)
    else $error("slot after alarm bytes not empty");
  a_power_zero: assert property (reg_rd_i && reg_addr_i == rtcal_pkg::ADDR_POWER
    |=> reg_rdata_o == 8'h00) else $error("power control read not zero");
  a_ctrl_low: assert property (reg_rd_i && reg_addr_i == rtcal_pkg::ADDR_CTRL
    |=> reg_rdata_o[3:0] == 4'h0) else $error("control low bits not zero");
  a_fall_tick: assert property ($fell(irq_n_o) |-> $past(tick_i))
    else $error("interrupt fell without a tick");
  a_clear_release: assert property (!per_q && reg_wr_i && !tick_i
    && reg_addr_i == rtcal_pkg::ADDR_STATUS && reg_wdata_i[1:0] == 2'b00 ##1 !tick_i
    |=> irq_n_o) else $error("interrupt stayed low after both flags cleared");
  a_pulse_width: assert property ($rose(irq_n_o) && per_q && $past(per_q)
    |-> int'(low_q) >= IRQ_PULSE_CYCLES) else $error("interrupt pulse too short");
endmodule : rtcal_sva

bind rtcal_top rtcal_sva #(.IRQ_PULSE_CYCLES(IRQ_PULSE_CYCLES)) i_sva (
  .core_clk_i(core_clk_i), .reset_i(reset_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .time_i(time_i), .tick_i(tick_i),
  .on_battery_i(on_battery_i), .event_i(event_i), .irq_n_o(irq_n_o)
);

// ### test/tb.sv
// Self-checking bench for the alarm and stamp block with a host register model.
// Assumes a short interrupt pulse parameter so pulse widths are quick to count.
`timescale 1ns/10ps
module tb;
  localparam int PW = 4;
  localparam logic [7:0] ST = rtcal_pkg::ADDR_STATUS;
  localparam logic [7:0] CT = rtcal_pkg::ADDR_CTRL;
  localparam logic [7:0] A0 = rtcal_pkg::ADDR_ALARM0;
  logic core_clk_i, reset_i, reg_wr, reg_rd, tick, on_batt, evt, irq_n;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [rtcal_pkg::NUM_FIELDS-1:0][7:0] tm;
  int n_mismatch = 0;
  int checked = 0;

  rtcal_top #(.IRQ_PULSE_CYCLES(PW)) i_dut (.core_clk_i(core_clk_i), .reset_i(reset_i),
    .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
    .reg_rdata_o(reg_rdata), .time_i(tm), .tick_i(tick), .on_battery_i(on_batt),
    .event_i(evt), .irq_n_o(irq_n));
  rtcal_host i_host (.core_clk_i(core_clk_i), .reg_rdata_i(reg_rdata), .reg_addr_o(reg_addr),
    .reg_wdata_o(reg_wdata), .reg_wr_o(reg_wr), .reg_rd_o(reg_rd));

  initial begin
    core_clk_i = 1'b0;
    forever #12.5 core_clk_i = ~core_clk_i;
  end

  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : print_verdict

  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic rchk(input logic [7:0] a, input logic [7:0] exp, input logic [7:0] m = 8'hff);
    logic [7:0] d;
    i_host.rd(a, d);
    chk($sformatf("register %h", a), exp, d & m);
  endtask : rchk

  task automatic tk(input logic [7:0] h, input logic [7:0] mi, input logic [7:0] s);
    @(negedge core_clk_i);
    tm[rtcal_pkg::FLD_HOUR] = h;
    tm[rtcal_pkg::FLD_MIN] = mi;
    tm[rtcal_pkg::FLD_SEC] = s;
    tick = 1'b1;
    @(negedge core_clk_i);
    tick = 1'b0;
  endtask : tk

  task automatic bat(input logic v);
    @(negedge core_clk_i);
    on_batt = v;
    @(negedge core_clk_i);
  endtask : bat

  task automatic pw();
    int n;
    n = 0;
    while (irq_n === 1'b0 && n < 100) begin
      n++;
      @(negedge core_clk_i);
    end
    if (n >= 100) begin
      n_mismatch++;
      $display("unexpected pulse width: expected %0d, seen no end", PW);
      print_verdict();
    end else begin
      chk("pulse width", 8'(PW), 8'(n));
    end
  endtask : pw

  function automatic logic [7:0] sa(input int e, input int b);
    return rtcal_pkg::ADDR_STAMP_BASE + 8'(e * 8 + b);
  endfunction : sa

  task automatic t_reset();
    chk("irq", 8'h01, {7'h00, irq_n});
    rchk(A0 + 8'h03, 8'h01);
    rchk(A0, 8'h00);
    rchk(CT, 8'h00);
    rchk(8'h29, 8'h00);
    rchk(sa(0, 4), 8'h00);
    rchk(sa(2, 3), 8'h00);
    $display("t_reset done");
  endtask : t_reset

  task automatic t_single();
    i_host.wr(A0 + 8'h01, 8'hb0);
    i_host.wr(rtcal_pkg::ADDR_ALARM1, 8'h85);
    i_host.wr(CT, 8'h30);
    tk(8'h10, 8'h29, 8'h59);
    chk("irq", 8'h01, {7'h00, irq_n});
    tk(8'h10, 8'h30, 8'h00);
    chk("irq", 8'h00, {7'h00, irq_n});
    rchk(ST, 8'h01, 8'h03);
    tk(8'h10, 8'h30, 8'h05);
    rchk(ST, 8'h03, 8'h03);
    i_host.wr(ST, 8'h02);
    tk(8'h10, 8'h30, 8'h06);
    chk("irq", 8'h00, {7'h00, irq_n});
    rchk(ST, 8'h02, 8'h03);
    i_host.wr(ST, 8'h00);
    @(negedge core_clk_i);
    chk("irq", 8'h01, {7'h00, irq_n});
    $display("t_single done");
  endtask : t_single

  task automatic t_autoclr();
    i_host.wr(CT, 8'h90);
    tk(8'h10, 8'h31, 8'h00);
    tk(8'h11, 8'h30, 8'h00);
    chk("irq", 8'h00, {7'h00, irq_n});
    rchk(ST, 8'h01, 8'h03);
    @(negedge core_clk_i);
    chk("irq", 8'h01, {7'h00, irq_n});
    rchk(ST, 8'h00, 8'h03);
    $display("t_autoclr done");
  endtask : t_autoclr

  task automatic t_periodic();
    i_host.wr(A0 + 8'h01, 8'h00);
    i_host.wr(A0, 8'hb0);
    i_host.wr(CT, 8'h50);
    for (int k = 0; k < 2; k++) begin
      tk(8'h11, 8'h31, 8'h29);
      tk(8'h11, 8'h31, 8'h30);
      pw();
    end
    rchk(ST, 8'h01, 8'h01);
    i_host.wr(CT, 8'h40);
    tk(8'h11, 8'h32, 8'h29);
    tk(8'h11, 8'h32, 8'h30);
    chk("irq", 8'h01, {7'h00, irq_n});
    $display("t_periodic done");
  endtask : t_periodic

  task automatic t_stamps();
    tk(8'h08, 8'h15, 8'h21);
    bat(1'b1);
    rchk(sa(0, 0), 8'h21);
    rchk(sa(0, 4), 8'h07);
    tk(8'h08, 8'h16, 8'h33);
    bat(1'b0);
    rchk(sa(1, 0), 8'h33);
    tk(8'h08, 8'h17, 8'h44);
    bat(1'b1);
    tk(8'h08, 8'h18, 8'h55);
    bat(1'b0);
    rchk(sa(0, 0), 8'h21);
    rchk(sa(1, 0), 8'h55);
    i_host.wr(rtcal_pkg::ADDR_POWER, 8'h80);
    rchk(sa(0, 0), 8'h00);
    rchk(sa(1, 4), 8'h00);
    rchk(rtcal_pkg::ADDR_POWER, 8'h00);
    $display("t_stamps done");
  endtask : t_stamps

  task automatic t_events();
    for (int k = 1; k <= 5; k++) begin
      tk(8'h09, 8'h00, 8'(k));
      @(negedge core_clk_i);
      evt = 1'b1;
      @(negedge core_clk_i);
      evt = 1'b0;
    end
    rchk(rtcal_pkg::ADDR_EVT_COUNT, 8'h05);
    rchk(sa(2, 0), 8'h01);
    rchk(sa(3, 0), 8'h05);
    rchk(sa(4, 0), 8'h04);
    rchk(sa(5, 0), 8'h03);
    i_host.wr(rtcal_pkg::ADDR_EVT_COUNT, 8'h00);
    for (int k = 2; k < 6; k++) begin
      rchk(sa(k, 0), 8'h00);
    end
    $display("t_events done");
  endtask : t_events

  initial begin
    reset_i = 1'b1;
    tick = 1'b0;
    on_batt = 1'b0;
    evt = 1'b0;
    tm = {8'h00, 8'h07, 8'h01, 8'h00, 8'h00, 8'h00};
    repeat (4) @(posedge core_clk_i);
    @(negedge core_clk_i);
    reset_i = 1'b0;
    t_reset();
    t_single();
    t_autoclr();
    t_periodic();
    t_stamps();
    t_events();
    print_verdict();
  end
endmodule : tb
